// ===== verilog/regulator_output_config_pkg.sv
// Package with offsets, field positions and codes of the regulator output configuration bank.
package regulator_output_config_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int REG_COUNT = 8;
   localparam int INDEX_W = 3;
   localparam logic [7:0] BASE_OFFSET = 8'h04;
   localparam logic [7:0] BUCKBOOST_ONE_VOLTAGE_OFS = 8'h04;
   localparam logic [7:0] BUCKBOOST_ONE_CONFIG_OFS = 8'h05;
   localparam logic [7:0] BUCKBOOST_TWO_VOLTAGE_OFS = 8'h06;
   localparam logic [7:0] BUCKBOOST_TWO_CONFIG_OFS = 8'h07;
   localparam logic [7:0] LINEAR_ONE_VOLTAGE_OFS = 8'h08;
   localparam logic [7:0] LINEAR_ONE_CONFIG_OFS = 8'h09;
   localparam logic [7:0] LINEAR_TWO_VOLTAGE_OFS = 8'h0a;
   localparam logic [7:0] LINEAR_TWO_CONFIG_OFS = 8'h0b;
   localparam logic [7:0] LAST_OFFSET = 8'h0b;
   // Register indices inside the bank memory.
   localparam logic [2:0] IDX_BB1_V = 3'h0;
   localparam logic [2:0] IDX_BB1_C = 3'h1;
   localparam logic [2:0] IDX_BB2_V = 3'h2;
   localparam logic [2:0] IDX_BB2_C = 3'h3;
   localparam logic [2:0] IDX_L1_V = 3'h4;
   localparam logic [2:0] IDX_L1_C = 3'h5;
   localparam logic [2:0] IDX_L2_V = 3'h6;
   localparam logic [2:0] IDX_L2_C = 3'h7;
   // Writable bit masks; voltage registers keep bits 5:0, reserved bits read zero.
   localparam logic [7:0] VOLTAGE_MASK = 8'h3f;
   localparam logic [7:0] BB_CONFIG_MASK = 8'he8;
   localparam logic [7:0] L1_CONFIG_MASK = 8'hf1;
   localparam logic [7:0] L2_CONFIG_MASK = 8'he1;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Field positions.
   localparam int EN_HI = 7;
   localparam int EN_LO = 6;
   localparam int PASSIVE_DSC_BIT = 5;
   localparam int ACTIVE_DSC_BIT = 4;
   localparam int RAMP_DIS_BIT = 3;
   localparam int FUNC_SEL_BIT = 0;
   localparam int VCODE_HI = 5;
   localparam int VCODE_LO = 0;
   typedef enum logic [1:0] {
      EN_OFF = 2'h0,
      EN_ON = 2'h1,
      EN_PIN_LOW = 2'h2,
      EN_PIN_HIGH = 2'h3
   } enable_select_t;
endpackage

// ===== verilog/config_reg_mem.sv
// Small register memory holding the eight configuration bytes, with registered read data.
`timescale 1ns/100ps
module config_reg_mem
   import regulator_output_config_pkg::*;
(
   input wire logic ref_clk, // Register clock.
   input wire logic rst_n, // Asynchronous reset, active low.
   input wire logic wr_en, // Write strobe, one cycle.
   input wire logic [INDEX_W-1:0] wr_index, // Write index.
   input wire logic [DATA_W-1:0] wr_data, // Masked write data.
   input wire logic [INDEX_W-1:0] rd_index, // Read index.
   output logic [DATA_W-1:0] rd_data, // Registered read data.
   output logic [REG_COUNT*DATA_W-1:0] all_regs // Every stored byte, flattened.
);
   logic [DATA_W-1:0] mem_ff [REG_COUNT];
   logic [DATA_W-1:0] rd_data_ff;

   genvar gi;
   generate
      for (gi = 0; gi < REG_COUNT; gi++) begin : g_cell
         always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
               mem_ff[gi] <= REG_RESET;
            end else if (wr_en && wr_index == INDEX_W'(gi)) begin
               mem_ff[gi] <= wr_data;
            end
         end
         assign all_regs[gi*DATA_W +: DATA_W] = mem_ff[gi];
      end
   endgenerate

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_ff <= REG_RESET;
      end else begin
         rd_data_ff <= mem_ff[rd_index];
      end
   end
   assign rd_data = rd_data_ff;
endmodule // config_reg_mem

// ===== verilog/regulator_output_config_bank.sv
// Configuration register bank for two buck-boost and two linear regulator outputs.
//
// Function
// - Buck-boost one enable: 00 off, 01 on, 10 on while control pin low.
// - Buck-boost one enable code 11: on only while control pin high.
// - Buck-boost two enable bits 7:6 decode off, on, pin low, pin high.
// - Buck-boost one passive discharge bit set discharges output while it is off.
// - Buck-boost two passive discharge bit set discharges output while it is off.
// - Linear regulators: bit 5 set discharges the output while it is off.
// - Buck-boost one ramp-disable set applies new voltage at once, else ramps.
// - Buck-boost two ramp-disable set applies new voltage at once, else ramps.
// - Linear one bit 0: zero regulator, one load switch.
// - Linear two bit 0: zero regulator, one load switch.
`timescale 1ns/100ps
module regulator_output_config_bank
   import regulator_output_config_pkg::*;
(
   input wire logic ref_clk, // Serial interface clock, 20 MHz.
   input wire logic rst_n, // Power-on reset, active low.
   input wire logic reg_wr, // Register write strobe from the serial front end.
   input wire logic reg_rd, // Register read strobe from the serial front end.
   input wire logic [ADDR_W-1:0] reg_addr, // Register address.
   input wire logic [DATA_W-1:0] reg_wdata, // Write data.
   output logic [DATA_W-1:0] reg_rdata, // Read data, valid with reg_rvalid.
   output logic reg_rvalid, // Read data valid pulse.
   input wire logic multipurpose_control_pin, // Control pin level, synchronous.
   output logic buckboost_one_on, // Buck-boost one output enabled.
   output logic buckboost_two_on, // Buck-boost two output enabled.
   output logic linear_one_on, // Linear one output enabled.
   output logic linear_two_on, // Linear two output enabled.
   output logic buckboost_one_discharge, // Buck-boost one passive discharge applied.
   output logic buckboost_two_discharge, // Buck-boost two passive discharge applied.
   output logic linear_one_discharge, // Linear one passive discharge applied.
   output logic linear_two_discharge, // Linear two passive discharge applied.
   output logic linear_one_active_discharge, // Linear one active discharge setting.
   output logic [5:0] buckboost_one_voltage_code, // Buck-boost one target code.
   output logic [5:0] buckboost_two_voltage_code, // Buck-boost two target code.
   output logic [5:0] linear_one_voltage_code, // Linear one target code.
   output logic [5:0] linear_two_voltage_code, // Linear two target code.
   output logic buckboost_one_ramp_disable, // Buck-boost one immediate transition.
   output logic buckboost_two_ramp_disable, // Buck-boost two immediate transition.
   output logic buckboost_one_voltage_update, // Pulse: apply new code now, no ramp.
   output logic buckboost_two_voltage_update, // Pulse: apply new code now, no ramp.
   output logic linear_one_function_select, // Linear one: 0 regulator, 1 load switch.
   output logic linear_two_function_select // Linear two: 0 regulator, 1 load switch.
);
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      return (a >= BASE_OFFSET) && (a <= LAST_OFFSET);
   endfunction

   function automatic logic [INDEX_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - BASE_OFFSET;
      return d[INDEX_W-1:0];
   endfunction

   function automatic logic [DATA_W-1:0] write_mask(input logic [INDEX_W-1:0] i);
      logic [DATA_W-1:0] m;
      m = VOLTAGE_MASK;
      unique case (i)
         IDX_BB1_C, IDX_BB2_C: m = BB_CONFIG_MASK;
         IDX_L1_C: m = L1_CONFIG_MASK;
         IDX_L2_C: m = L2_CONFIG_MASK;
         default: m = VOLTAGE_MASK;
      endcase
      return m;
   endfunction

   // Decodes an enable field against the control pin level.
   function automatic logic enable_decode(input logic [1:0] sel, input logic pin);
      logic on;
      on = 1'b0;
      unique case (enable_select_t'(sel))
         EN_OFF: on = 1'b0;
         EN_ON: on = 1'b1;
         EN_PIN_LOW: on = ~pin;
         EN_PIN_HIGH: on = pin;
      endcase
      return on;
   endfunction

   logic wr_hit;
   logic [INDEX_W-1:0] wr_index;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] mem_rdata;
   logic [REG_COUNT*DATA_W-1:0] all_regs;
   logic rd_pending_ff;
   logic rd_hit_ff;
   logic [DATA_W-1:0] reg_rdata_ff;
   logic reg_rvalid_ff;
   logic [DATA_W-1:0] bb1_v, bb1_c, bb2_v, bb2_c, l1_v, l1_c, l2_v, l2_c;
   logic nxt_bb1_on, nxt_bb2_on, nxt_l1_on, nxt_l2_on;
   logic [3:0] on_ff;
   logic [3:0] dsc_ff;
   logic l1_adsc_ff;
   logic [5:0] vcode_ff [4];
   logic [1:0] ramp_dis_ff;
   logic [1:0] upd_ff;
   logic [1:0] func_ff;

   assign wr_hit = reg_wr && addr_hit(reg_addr);
   assign wr_index = addr_index(reg_addr);
   // reserved bits zero: only documented fields are stored.
   assign wr_data = reg_wdata & write_mask(wr_index);

   config_reg_mem u_mem (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(wr_hit),
      .wr_index(wr_index),
      .wr_data(wr_data),
      .rd_index(addr_index(reg_addr)),
      .rd_data(mem_rdata),
      .all_regs(all_regs)
   );

   assign bb1_v = all_regs[IDX_BB1_V*DATA_W +: DATA_W];
   assign bb1_c = all_regs[IDX_BB1_C*DATA_W +: DATA_W];
   assign bb2_v = all_regs[IDX_BB2_V*DATA_W +: DATA_W];
   assign bb2_c = all_regs[IDX_BB2_C*DATA_W +: DATA_W];
   assign l1_v = all_regs[IDX_L1_V*DATA_W +: DATA_W];
   assign l1_c = all_regs[IDX_L1_C*DATA_W +: DATA_W];
   assign l2_v = all_regs[IDX_L2_V*DATA_W +: DATA_W];
   assign l2_c = all_regs[IDX_L2_C*DATA_W +: DATA_W];

   // Read takes two cycles because the memory registers its data; unmapped reads return zero.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_pending_ff <= 1'b0;
         rd_hit_ff <= 1'b0;
      end else begin
         rd_pending_ff <= reg_rd;
         rd_hit_ff <= addr_hit(reg_addr);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_ff <= REG_RESET;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= rd_pending_ff;
         if (rd_pending_ff) begin
            reg_rdata_ff <= rd_hit_ff ? mem_rdata : REG_RESET;
         end
      end
   end

   always_comb begin
      nxt_bb1_on = enable_decode(bb1_c[EN_HI:EN_LO], multipurpose_control_pin);
      nxt_bb2_on = enable_decode(bb2_c[EN_HI:EN_LO], multipurpose_control_pin);
      nxt_l1_on = enable_decode(l1_c[EN_HI:EN_LO], multipurpose_control_pin);
      nxt_l2_on = enable_decode(l2_c[EN_HI:EN_LO], multipurpose_control_pin);
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         on_ff <= 4'h0;
      end else begin
         on_ff <= {nxt_l2_on, nxt_l1_on, nxt_bb2_on, nxt_bb1_on};
      end
   end

   // Discharge follows the same decoded enable, so it never overlaps a live output.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dsc_ff <= 4'h0;
         l1_adsc_ff <= 1'b0;
      end else begin
         dsc_ff[0] <= bb1_c[PASSIVE_DSC_BIT] & ~nxt_bb1_on;
         dsc_ff[1] <= bb2_c[PASSIVE_DSC_BIT] & ~nxt_bb2_on;
         dsc_ff[2] <= l1_c[PASSIVE_DSC_BIT] & ~nxt_l1_on;
         dsc_ff[3] <= l2_c[PASSIVE_DSC_BIT] & ~nxt_l2_on;
         l1_adsc_ff <= l1_c[ACTIVE_DSC_BIT];
      end
   end

   // A buck-boost voltage write that changes the code with ramp-disable set is flagged one cycle after it lands, when the stored code is visible.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            vcode_ff[i] <= 6'h00;
         end
         ramp_dis_ff <= 2'h0;
         upd_ff <= 2'h0;
      end else begin
         vcode_ff[0] <= bb1_v[VCODE_HI:VCODE_LO];
         vcode_ff[1] <= bb2_v[VCODE_HI:VCODE_LO];
         vcode_ff[2] <= l1_v[VCODE_HI:VCODE_LO];
         vcode_ff[3] <= l2_v[VCODE_HI:VCODE_LO];
         ramp_dis_ff[0] <= bb1_c[RAMP_DIS_BIT];
         upd_ff[0] <= bb1_c[RAMP_DIS_BIT] && (bb1_v[VCODE_HI:VCODE_LO] != vcode_ff[0]);
         ramp_dis_ff[1] <= bb2_c[RAMP_DIS_BIT];
         upd_ff[1] <= bb2_c[RAMP_DIS_BIT] && (bb2_v[VCODE_HI:VCODE_LO] != vcode_ff[1]);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         func_ff <= 2'h0;
      end else begin
         func_ff[0] <= l1_c[FUNC_SEL_BIT];
         func_ff[1] <= l2_c[FUNC_SEL_BIT];
      end
   end

   assign reg_rdata = reg_rdata_ff;
   assign reg_rvalid = reg_rvalid_ff;
   assign buckboost_one_on = on_ff[0];
   assign buckboost_two_on = on_ff[1];
   assign linear_one_on = on_ff[2];
   assign linear_two_on = on_ff[3];
   assign buckboost_one_discharge = dsc_ff[0];
   assign buckboost_two_discharge = dsc_ff[1];
   assign linear_one_discharge = dsc_ff[2];
   assign linear_two_discharge = dsc_ff[3];
   assign linear_one_active_discharge = l1_adsc_ff;
   assign buckboost_one_voltage_code = vcode_ff[0];
   assign buckboost_two_voltage_code = vcode_ff[1];
   assign linear_one_voltage_code = vcode_ff[2];
   assign linear_two_voltage_code = vcode_ff[3];
   assign buckboost_one_ramp_disable = ramp_dis_ff[0];
   assign buckboost_two_ramp_disable = ramp_dis_ff[1];
   assign buckboost_one_voltage_update = upd_ff[0];
   assign buckboost_two_voltage_update = upd_ff[1];
   assign linear_one_function_select = func_ff[0];
   assign linear_two_function_select = func_ff[1];
endmodule // regulator_output_config_bank

// ===== tb/regulator_output_config_bank_sva.sv
// Assertion checker for the regulator output configuration bank.
`timescale 1ns/100ps
module regulator_output_config_bank_sva
   import regulator_output_config_pkg::*;
(
   input wire logic ref_clk, // Clock.
   input wire logic rst_n, // Reset.
   input wire logic reg_wr, // Write.
   input wire logic reg_rd, // Read.
   input wire logic [ADDR_W-1:0] reg_addr, // Address.
   input wire logic [DATA_W-1:0] reg_wdata, // Data in.
   input wire logic [DATA_W-1:0] reg_rdata, // Data out.
   input wire logic reg_rvalid, // Valid.
   input wire logic multipurpose_control_pin, // Pin.
   input wire logic buckboost_one_on, // On.
   input wire logic buckboost_two_on, // On.
   input wire logic linear_one_on, // On.
   input wire logic buckboost_one_discharge, // Drain.
   input wire logic buckboost_two_discharge, // Drain.
   input wire logic linear_one_discharge, // Drain.
   input wire logic [5:0] buckboost_one_voltage_code, // Code.
   input wire logic buckboost_one_ramp_disable, // Ramp.
   input wire logic buckboost_one_voltage_update, // Pulse.
   input wire logic linear_one_function_select, // Mode.
   input wire logic linear_two_function_select // Mode.
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire logic [1:0] en = reg_wdata[7:6];
   wire logic w05 = reg_wr && reg_addr == 8'h05;
   wire logic w07 = reg_wr && reg_addr == 8'h07;
   wire logic w09 = reg_wr && reg_addr == 8'h09;
   wire logic w04 = reg_wr && reg_addr == 8'h04;
   wire logic w0b = reg_wr && reg_addr == 8'h0b;
   wire logic w05_hi = w05 && en == EN_PIN_HIGH;
   wire logic w07_hi = w07 && en == EN_PIN_HIGH;
   wire logic w09_lo = w09 && en == EN_PIN_LOW;
   wire logic unmapped = reg_addr < BASE_OFFSET || reg_addr > LAST_OFFSET;
   wire logic [5:0] wvc = reg_wdata[5:0];
   wire logic wb0 = reg_wdata[0];
   wire logic wb5 = reg_wdata[5];
   wire logic pin = multipurpose_control_pin;
   rd_answer_a: assert property (reg_rd |-> ##[1:3] reg_rvalid) else $error("read not answered");
   unmapped_zero_a: assert property (reg_rd && unmapped |-> ##[1:3] (reg_rvalid && reg_rdata == 8'h00))
      else $error("unmapped read not zero");
   vcode_store_a: assert property (w04 |-> ##3 buckboost_one_voltage_code == $past(wvc, 3))
      else $error("voltage code wrong");
   bb1_off_a: assert property (w05 && en == EN_OFF |-> ##3 !buckboost_one_on) else $error("bb1 not off");
   bb1_on_a: assert property (w05 && en == EN_ON |-> ##3 buckboost_one_on) else $error("bb1 not on");
   bb1_pin_a: assert property (w05_hi ##1 $stable(pin) [*2] |-> ##1 buckboost_one_on == $past(pin))
      else $error("bb1 pin high wrong");
   bb2_pin_a: assert property (w07_hi ##1 $stable(pin) [*2] |-> ##1 buckboost_two_on == $past(pin))
      else $error("bb2 pin high wrong");
   l1_pin_a: assert property (w09_lo ##1 $stable(pin) [*2] |-> ##1 linear_one_on == !$past(pin))
      else $error("l1 pin low wrong");
   bb1_dsc_a: assert property (buckboost_one_discharge |-> !buckboost_one_on) else $error("bb1 drain on");
   bb2_dsc_a: assert property (buckboost_two_discharge |-> !buckboost_two_on) else $error("bb2 drain on");
   l1_dsc_a: assert property (w09 && en == EN_OFF && wb5 |-> ##3 linear_one_discharge)
      else $error("l1 drain missing");
   // An update must come with ramping off and with a code that really moved.
   upd_ramp_a: assert property (buckboost_one_voltage_update |->
      buckboost_one_ramp_disable && $changed(buckboost_one_voltage_code)) else $error("update while ramping");
   fsel_one_a: assert property (w09 |-> ##3 linear_one_function_select == $past(wb0, 3))
      else $error("l1 mode wrong");
   fsel_two_a: assert property (w0b |-> ##3 linear_two_function_select == $past(wb0, 3))
      else $error("l2 mode wrong");
   cover property (reg_rvalid);
   cover property (buckboost_one_voltage_update);
   cover property (buckboost_two_on && pin);
endmodule // regulator_output_config_bank_sva
bind regulator_output_config_bank regulator_output_config_bank_sva regulator_output_config_bank_sva_inst (
   .ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
   .multipurpose_control_pin, .buckboost_one_on, .buckboost_two_on, .linear_one_on,
   .buckboost_one_discharge, .buckboost_two_discharge, .linear_one_discharge, .buckboost_one_voltage_code,
   .buckboost_one_ramp_disable, .buckboost_one_voltage_update, .linear_one_function_select,
   .linear_two_function_select);

// ===== tb/host_model.sv
// Host model issuing register writes and reads on the strobe interface.
`timescale 1ns/100ps
module host_model
   import regulator_output_config_pkg::*;
(
   input wire logic ref_clk, // Clock.
   output logic reg_wr, // Write strobe.
   output logic reg_rd, // Read strobe.
   output logic [ADDR_W-1:0] reg_addr, // Address.
   output logic [DATA_W-1:0] reg_wdata, // Write data.
   input wire logic [DATA_W-1:0] reg_rdata, // Read data.
   input wire logic reg_rvalid // Read valid.
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // Released buses show the inverse so stale values cannot pass unnoticed.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge ref_clk);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge ref_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      repeat (4) begin
         if (!ok && reg_rvalid === 1'b1) begin
            ok = 1'b1;
            d = reg_rdata;
         end
         @(posedge ref_clk);
         #1;
      end
   endtask
endmodule // host_model

// ===== tb/tb_regulator_output_config_bank.sv
// Self-checking testbench for the regulator output configuration bank.
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
   $display("[ERR] %s exp %h seen %h", n, e, g); end end
module tb_regulator_output_config_bank
   import regulator_output_config_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic multipurpose_control_pin = 1'b0;
   logic reg_wr, reg_rd, reg_rvalid, rok;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rdat;
   logic buckboost_one_on, buckboost_two_on, linear_one_on, linear_two_on;
   logic buckboost_one_discharge, buckboost_two_discharge, linear_one_discharge, linear_two_discharge;
   logic linear_one_active_discharge, buckboost_one_ramp_disable, buckboost_two_ramp_disable;
   logic buckboost_one_voltage_update, buckboost_two_voltage_update;
   logic linear_one_function_select, linear_two_function_select;
   logic [5:0] buckboost_one_voltage_code, buckboost_two_voltage_code;
   logic [5:0] linear_one_voltage_code, linear_two_voltage_code;
   wire logic [3:0] on_all = {buckboost_one_on, buckboost_two_on, linear_one_on, linear_two_on};
   wire logic [3:0] dsc_all = {buckboost_one_discharge, buckboost_two_discharge, linear_one_discharge,
      linear_two_discharge};
   wire logic [23:0] code_all = {buckboost_one_voltage_code, buckboost_two_voltage_code, linear_one_voltage_code,
      linear_two_voltage_code};
   wire logic [2:0] fsel_all = {linear_one_function_select, linear_two_function_select,
      linear_one_active_discharge};
   int errors = 0;
   int samples_checked = 0;
   int upd1 = 0;
   int upd2 = 0;
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      upd1 <= upd1 + int'(buckboost_one_voltage_update);
      upd2 <= upd2 + int'(buckboost_two_voltage_update);
   end
   regulator_output_config_bank regulator_output_config_bank_inst (
      .ref_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
      .multipurpose_control_pin, .buckboost_one_on, .buckboost_two_on, .linear_one_on, .linear_two_on,
      .buckboost_one_discharge, .buckboost_two_discharge, .linear_one_discharge, .linear_two_discharge,
      .linear_one_active_discharge, .buckboost_one_voltage_code, .buckboost_two_voltage_code,
      .linear_one_voltage_code, .linear_two_voltage_code, .buckboost_one_ramp_disable,
      .buckboost_two_ramp_disable, .buckboost_one_voltage_update, .buckboost_two_voltage_update,
      .linear_one_function_select, .linear_two_function_select);
   host_model host_model_inst (.ref_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      host_model_inst.rd(a, rdat, rok);
      `CHK("rdata", e, rdat)
      `CHK("rvalid", 1'b1, rok)
   endtask
   task automatic wcfg(input logic [7:0] d);
      for (int i = 0; i < 4; i++) host_model_inst.wr(8'h05 + 8'(2 * i), d);
      settle();
   endtask
   task automatic t_reset();
      for (int i = 0; i < 8; i++) rd_chk(8'h04 + 8'(i), 8'h00);
      `CHK("on", 4'h0, {buckboost_one_on, buckboost_two_on, linear_one_on, linear_two_on})
   endtask
   task automatic t_voltage();
      logic [23:0] e = '0;
      for (int i = 0; i < 4; i++) begin
         host_model_inst.wr(8'h04 + 8'(2 * i), 8'hc0 | 8'(13 * i + 5));
         e = {e[17:0], 6'(13 * i + 5)};
      end
      settle();
      `CHK("codes", e, code_all)
      for (int i = 0; i < 4; i++) rd_chk(8'h04 + 8'(2 * i), 8'(13 * i + 5));
      host_model_inst.wr(8'h0a, 8'hff);
      settle();
      rd_chk(8'h0a, 8'h3f);
      `CHK("l2 code", 6'h3f, linear_two_voltage_code)
   endtask
   task automatic t_enable();
      logic e;
      for (int c = 0; c < 4; c++) begin
         wcfg(8'(c << 6));
         for (int p = 0; p < 2; p++) begin
            multipurpose_control_pin = p[0];
            settle();
            e = (c == 1) || (c == 2 && p == 0) || (c == 3 && p == 1);
            `CHK("on", {4{e}}, on_all)
         end
      end
   endtask
   // The pin is left high, so the pin-low code 8'ha0 leaves every output off.
   task automatic t_dsc();
      logic [7:0] cfg [4] = '{8'h20, 8'h60, 8'ha0, 8'h00};
      for (int i = 0; i < 4; i++) begin
         wcfg(cfg[i]);
         `CHK("dsc", {4{i[0] == 1'b0 && i < 3}}, dsc_all)
      end
   endtask
   task automatic t_ramp();
      int b1, b2;
      for (int r = 0; r < 2; r++) begin
         host_model_inst.wr(8'h05, r ? 8'h40 : 8'h48);
         host_model_inst.wr(8'h07, r ? 8'h40 : 8'h48);
         settle();
         `CHK("ramp", r ? 2'b00 : 2'b11, {buckboost_one_ramp_disable, buckboost_two_ramp_disable})
         b1 = upd1;
         b2 = upd2;
         host_model_inst.wr(8'h04, 8'h2a + 8'(r));
         host_model_inst.wr(8'h06, 8'h15 + 8'(r));
         settle();
         settle();
         `CHK("pulse1", r ? 0 : 1, upd1 - b1)
         `CHK("pulse2", r ? 0 : 1, upd2 - b2)
      end
   endtask
   task automatic t_fsel();
      host_model_inst.wr(8'h09, 8'h11);
      host_model_inst.wr(8'h0b, 8'h1f);
      host_model_inst.wr(8'h0c, 8'h5a);
      settle();
      `CHK("fsel", 3'b111, fsel_all)
      rd_chk(8'h09, 8'h11);
      rd_chk(8'h0b, 8'h01);
      rd_chk(8'h0c, 8'h00);
      rd_chk(8'h03, 8'h00);
      host_model_inst.wr(8'h09, 8'h00);
      host_model_inst.wr(8'h0b, 8'h00);
      settle();
      `CHK("fsel", 2'b00, {linear_one_function_select, linear_two_function_select})
   endtask
   // A reset in mid-run must clear all four enable outputs and the stored 0x05 configuration byte.
   task automatic t_rst();
      wcfg(8'h60);
      `CHK("on before rst", 4'hf, on_all)
      rst_n = 1'b0;
      settle();
      rst_n = 1'b1;
      `CHK("on after rst", 4'h0, on_all)
      rd_chk(8'h05, 8'h00);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      t_reset();
      t_voltage();
      t_enable();
      t_dsc();
      t_ramp();
      t_fsel();
      t_rst();
      print_verdict();
   end
   // The tests need under a thousand cycles; five thousand leaves ample margin.
   initial begin
      #250000;
      errors++;
      print_verdict();
   end
endmodule // tb_regulator_output_config_bank
